// ==== pgfr_pkg.sv ====
// Constants and helpers for the power-good and fault-response block
// Summary of operation
// - Power-good released only after start-up and while output sits inside window.
// - Window bounds come from OV and UV warning limits of window select command.
// - Power-good pulled low whenever any fault whose response is not ignore is active.
// - Feedback prebiased more than 5% above regulation trips OV warning, drops power-good.
// - Internal overtemp fault: latch-off kills switches and power-good; ignore keeps both.
// - Restart on internal overtemp: switches off, power-good low, restart once cooled.
// - Overtemp or low-side overcurrent warning keeps PWM; power-good follows fault response.
// - Bandgap overtemp always shuts switches off, power-good low, restarts after cooling.
// - Overcurrent latch-off: after 3 PWM counts switches off, power-good low; ignore continues.
// - Overcurrent restart: switches off after 3 counts, retry after seven rise times.
// - Overcurrent fault needs three consecutive events; flags status, alerts unless masked.
`default_nettype none
package pgfr_pkg;
    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_OC_FLT = 8'h46;
    localparam logic [7:0] CMD_OC_RESP = 8'h47;
    localparam logic [7:0] CMD_OT_FLT = 8'h4f;
    localparam logic [7:0] CMD_OT_RESP = 8'h50;
    localparam logic [7:0] CMD_OT_WRN = 8'h51;
    localparam logic [7:0] CMD_WIN_SEL = 8'hd7;
    localparam logic [7:0] CMD_STATUS = 8'he0;
    localparam logic [7:0] CMD_MASK = 8'he1;
    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [15:0] RST_OC_FLT = 16'h0023;
    localparam logic [15:0] RST_OT_FLT = 16'h007d;
    localparam logic [15:0] RST_OT_WRN = 16'h0069;
    localparam logic [7:0] RST_WIN_SEL = 8'h00;
    localparam logic [1:0] RST_OT_RESP = 2'h0;
    localparam logic [1:0] RST_OC_RESP = 2'h1;
    localparam logic [7:0] RST_MASK = 8'h00;
    // ****************************************
    // Fault responses
    // ****************************************
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_LATCH = 2'h1;
    localparam logic [1:0] RESP_RESTART = 2'h2;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int WIN_OV_LSB = 0;
    localparam int WIN_UV_LSB = 2;
    localparam int ST_OT_FLT = 0;
    localparam int ST_OT_WRN = 1;
    localparam int ST_BG_OT = 2;
    localparam int ST_OC_FLT = 3;
    localparam int ST_OC_WRN = 4;
    localparam int ST_OV_WRN = 5;
    localparam int ST_UV_WRN = 6;
    localparam int ST_PG_LOW = 7;
    // ****************************************
    // Counts and limits
    // ****************************************
    localparam logic [1:0] OC_EVENTS = 2'h3;
    localparam logic [15:0] OT_HYST = 16'h0014;
    localparam logic [7:0] PREBIAS_PCT = 8'h05;
    localparam logic [31:0] RESTART_RISES = 32'h0000_0007;
    localparam int SOFT_START_RISE_US = 1000;
    localparam int CLK_MHZ = 200;
    localparam int SOFT_START_RISE_CYC = SOFT_START_RISE_US * CLK_MHZ;

    // Percent of regulation for each window select code
    function automatic logic [7:0] win_pct(input logic [1:0] sel);
        unique case (sel)
            2'h0: win_pct = 8'h05;
            2'h1: win_pct = 8'h03;
            2'h2: win_pct = 8'h07;
            2'h3: win_pct = 8'h0a;
        endcase
    endfunction : win_pct

    // Fraction of the reference, truncated toward zero
    function automatic logic [15:0] pct_of(input logic [15:0] ref_v, input logic [7:0] pct);
        logic [23:0] prod;
        prod = ref_v * pct;
        pct_of = 16'((prod / 24'h000064));
    endfunction : pct_of
endpackage : pgfr_pkg
`default_nettype wire

// ==== pgfr_oc_count.sv ====
// Consecutive overcurrent event counter
`timescale 1ns/1ps
`default_nettype none
module pgfr_oc_count (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic evt_i,
    input wire logic clr_i,
    output logic fault_o
);
    logic seen_reg;
    logic [1:0] cnt_reg;

    // ****************************************
    // Event capture per PWM period
    // ****************************************
    // Event in the tick cycle counts for the period that ends
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            seen_reg <= 1'b0;
        end else if (tick_i) begin
            seen_reg <= 1'b0;
        end else if (evt_i) begin
            seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clr_i) begin
            cnt_reg <= 2'h0;
        end else if (tick_i) begin
            if (!(seen_reg || evt_i)) begin
                cnt_reg <= 2'h0;
            end else if (cnt_reg != pgfr_pkg::OC_EVENTS) begin
                cnt_reg <= cnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clr_i) begin
            fault_o <= 1'b0;
        end else if (tick_i && (seen_reg || evt_i) && cnt_reg == pgfr_pkg::OC_EVENTS - 2'h1) begin
            fault_o <= 1'b1;
        end
    end
endmodule : pgfr_oc_count
`default_nettype wire

// ==== pgfr_top.sv ====
// Power-good indicator and fault-response controller
`timescale 1ns/1ps
`default_nettype none
module pgfr_top #(
    parameter int SOFT_START_CYC = pgfr_pkg::SOFT_START_RISE_CYC
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic REMOTE_ON_CONTROL_I,
    input wire logic HS_OC_EVT_I,
    input wire logic LS_OC_EVT_I,
    input wire logic LS_OC_WARN_I,
    input wire logic BG_OT_I,
    input wire logic PWM_TICK_I,
    input wire logic [15:0] TEMP_CODE_I,
    input wire logic [15:0] FEEDBACK_SENSE_I,
    input wire logic [15:0] VREF_CODE_I,
    input wire logic CMD_WR_I,
    input wire logic [7:0] CMD_CODE_I,
    input wire logic [15:0] CMD_WDATA_I,
    output logic [15:0] CMD_RDATA_O,
    output logic [15:0] OC_LIMIT_O,
    output logic PWM_EN_O,
    output logic POWER_GOOD_OUT_O,
    output logic POWER_GOOD_OUT_OE_O,
    output logic ALERT_O,
    output logic ALERT_OE_O
);
    typedef enum logic [2:0] {
        ST_OFF, ST_SOFT, ST_RUN, ST_LATCH, ST_HICCUP, ST_COOL, ST_BGWAIT
    } pgfr_state_t;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Analog comparator outputs are asynchronous to the core clock
    logic [4:0] sync_a_reg;
    logic [4:0] sync_b_reg;
    logic on_s;
    logic hs_oc_s;
    logic ls_oc_s;
    logic ls_wrn_s;
    logic bg_ot_s;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            sync_a_reg <= 5'h00;
            sync_b_reg <= 5'h00;
        end else begin
            sync_a_reg <= {BG_OT_I, LS_OC_WARN_I, LS_OC_EVT_I, HS_OC_EVT_I, REMOTE_ON_CONTROL_I};
            sync_b_reg <= sync_a_reg;
        end
    end
    assign on_s = sync_b_reg[0];
    assign hs_oc_s = sync_b_reg[1];
    assign ls_oc_s = sync_b_reg[2];
    assign ls_wrn_s = sync_b_reg[3];
    assign bg_ot_s = sync_b_reg[4];

    // ****************************************
    // Command registers
    // ****************************************
    logic [15:0] oc_flt_reg;
    logic [15:0] ot_flt_reg;
    logic [15:0] ot_wrn_reg;
    logic [7:0] win_sel_reg;
    logic [1:0] ot_resp_reg;
    logic [1:0] oc_resp_reg;
    logic [7:0] mask_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] event_now;
    logic status_clr;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            oc_flt_reg <= pgfr_pkg::RST_OC_FLT;
            ot_flt_reg <= pgfr_pkg::RST_OT_FLT;
            ot_wrn_reg <= pgfr_pkg::RST_OT_WRN;
            win_sel_reg <= pgfr_pkg::RST_WIN_SEL;
            ot_resp_reg <= pgfr_pkg::RST_OT_RESP;
            oc_resp_reg <= pgfr_pkg::RST_OC_RESP;
            mask_reg <= pgfr_pkg::RST_MASK;
        end else if (CMD_WR_I) begin
            unique case (CMD_CODE_I)
                pgfr_pkg::CMD_OC_FLT: oc_flt_reg <= CMD_WDATA_I;
                pgfr_pkg::CMD_OT_FLT: ot_flt_reg <= CMD_WDATA_I;
                pgfr_pkg::CMD_OT_WRN: ot_wrn_reg <= CMD_WDATA_I;
                pgfr_pkg::CMD_WIN_SEL: win_sel_reg <= CMD_WDATA_I[7:0];
                pgfr_pkg::CMD_OT_RESP: ot_resp_reg <= CMD_WDATA_I[1:0];
                pgfr_pkg::CMD_OC_RESP: oc_resp_reg <= CMD_WDATA_I[1:0];
                pgfr_pkg::CMD_MASK: mask_reg <= CMD_WDATA_I[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            CMD_RDATA_O <= 16'h0000;
        end else begin
            unique case (CMD_CODE_I)
                pgfr_pkg::CMD_OC_FLT: CMD_RDATA_O <= oc_flt_reg;
                pgfr_pkg::CMD_OT_FLT: CMD_RDATA_O <= ot_flt_reg;
                pgfr_pkg::CMD_OT_WRN: CMD_RDATA_O <= ot_wrn_reg;
                pgfr_pkg::CMD_WIN_SEL: CMD_RDATA_O <= {8'h00, win_sel_reg};
                pgfr_pkg::CMD_OT_RESP: CMD_RDATA_O <= {14'h0000, ot_resp_reg};
                pgfr_pkg::CMD_OC_RESP: CMD_RDATA_O <= {14'h0000, oc_resp_reg};
                pgfr_pkg::CMD_STATUS: CMD_RDATA_O <= {8'h00, status_reg};
                pgfr_pkg::CMD_MASK: CMD_RDATA_O <= {8'h00, mask_reg};
                default: CMD_RDATA_O <= 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            OC_LIMIT_O <= pgfr_pkg::RST_OC_FLT;
        end else begin
            OC_LIMIT_O <= oc_flt_reg;
        end
    end

    // ****************************************
    // Detection
    // ****************************************
    logic [15:0] ov_lim;
    logic [15:0] uv_lim;
    logic [15:0] pre_lim;
    logic [16:0] ov_sum;
    logic [16:0] pre_sum;
    logic ov_wrn;
    logic uv_wrn;
    logic ot_flt;
    logic ot_wrn;
    logic ot_cool;
    logic oc_flt;
    logic oc_clr;

    assign ov_sum = {1'b0, VREF_CODE_I} + {1'b0, pgfr_pkg::pct_of(VREF_CODE_I,
        pgfr_pkg::win_pct(win_sel_reg[pgfr_pkg::WIN_OV_LSB +: 2]))};
    assign ov_lim = ov_sum[16] ? 16'hffff : ov_sum[15:0];
    assign uv_lim = VREF_CODE_I - pgfr_pkg::pct_of(VREF_CODE_I,
        pgfr_pkg::win_pct(win_sel_reg[pgfr_pkg::WIN_UV_LSB +: 2]));
    assign pre_sum = {1'b0, VREF_CODE_I} + {1'b0, pgfr_pkg::pct_of(VREF_CODE_I,
        pgfr_pkg::PREBIAS_PCT)};
    assign pre_lim = pre_sum[16] ? 16'hffff : pre_sum[15:0];
    assign ov_wrn = (FEEDBACK_SENSE_I > ov_lim) || (FEEDBACK_SENSE_I > pre_lim);
    assign uv_wrn = FEEDBACK_SENSE_I < uv_lim;
    assign ot_flt = TEMP_CODE_I > ot_flt_reg;
    assign ot_wrn = TEMP_CODE_I > ot_wrn_reg;
    // Cooling uses a fixed hysteresis below the fault threshold
    assign ot_cool = ({16'h0000, TEMP_CODE_I} + {16'h0000, pgfr_pkg::OT_HYST})
        <= {16'h0000, ot_flt_reg};

    pgfr_oc_count u_oc (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .tick_i(PWM_TICK_I),
        .evt_i(hs_oc_s || ls_oc_s),
        .clr_i(oc_clr),
        .fault_o(oc_flt)
    );

    // ****************************************
    // Response state machine
    // ****************************************
    pgfr_state_t state_reg;
    pgfr_state_t state_next;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic running;

    assign running = (state_reg == ST_SOFT) || (state_reg == ST_RUN);
    assign oc_clr = !running;

    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg != 32'h0000_0000) ? cnt_reg - 32'h0000_0001 : cnt_reg;
        unique case (state_reg)
            ST_OFF: begin
                if (on_s && !bg_ot_s) begin
                    state_next = ST_SOFT;
                    cnt_next = 32'(SOFT_START_CYC);
                end
            end
            ST_SOFT, ST_RUN: begin
                if (state_reg == ST_SOFT && cnt_reg == 32'h0000_0000) begin
                    state_next = ST_RUN;
                end
                if (!on_s) begin
                    state_next = ST_OFF;
                end else if (bg_ot_s) begin
                    state_next = ST_BGWAIT;
                end else if (ot_flt && ot_resp_reg == pgfr_pkg::RESP_LATCH) begin
                    state_next = ST_LATCH;
                end else if (ot_flt && ot_resp_reg == pgfr_pkg::RESP_RESTART) begin
                    state_next = ST_COOL;
                end else if (oc_flt && oc_resp_reg == pgfr_pkg::RESP_LATCH) begin
                    state_next = ST_LATCH;
                end else if (oc_flt && oc_resp_reg == pgfr_pkg::RESP_RESTART) begin
                    state_next = ST_HICCUP;
                    cnt_next = 32'(SOFT_START_CYC) * pgfr_pkg::RESTART_RISES;
                end
            end
            // Latch-off clears only through the remote on control
            ST_LATCH: begin
                if (!on_s) begin
                    state_next = ST_OFF;
                end
            end
            ST_HICCUP: begin
                if (!on_s) begin
                    state_next = ST_OFF;
                end else if (cnt_reg == 32'h0000_0000) begin
                    state_next = ST_OFF;
                end
            end
            ST_COOL: begin
                if (!on_s || ot_cool) begin
                    state_next = ST_OFF;
                end
            end
            ST_BGWAIT: begin
                if (!bg_ot_s) begin
                    state_next = ST_OFF;
                end
            end
            default: state_next = ST_OFF;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            state_reg <= ST_OFF;
            cnt_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // ****************************************
    // Status and alert
    // ****************************************
    logic pg_ok;
    logic wrn_pull;

    assign wrn_pull = (ot_wrn && ot_resp_reg != pgfr_pkg::RESP_IGNORE)
        || (ls_wrn_s && oc_resp_reg != pgfr_pkg::RESP_IGNORE);
    // released only in window after start-up
    assign pg_ok = (state_next == ST_RUN) && (state_reg == ST_RUN)
        && !ov_wrn && !uv_wrn && !wrn_pull;

    assign event_now[pgfr_pkg::ST_OT_FLT] = ot_flt;
    assign event_now[pgfr_pkg::ST_OT_WRN] = ot_wrn;
    assign event_now[pgfr_pkg::ST_BG_OT] = bg_ot_s;
    assign event_now[pgfr_pkg::ST_OC_FLT] = oc_flt;
    assign event_now[pgfr_pkg::ST_OC_WRN] = ls_wrn_s;
    assign event_now[pgfr_pkg::ST_OV_WRN] = ov_wrn;
    assign event_now[pgfr_pkg::ST_UV_WRN] = uv_wrn && (state_reg == ST_RUN);
    assign event_now[pgfr_pkg::ST_PG_LOW] = (state_reg == ST_RUN) && !pg_ok;

    // Write-one-to-clear; a new event in the same cycle wins
    assign status_clr = CMD_WR_I && (CMD_CODE_I == pgfr_pkg::CMD_STATUS);
    assign status_next = (status_reg & ~(status_clr ? CMD_WDATA_I[7:0] : 8'h00))
        | event_now;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            status_reg <= 8'h00;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            ALERT_O <= 1'b0;
            ALERT_OE_O <= 1'b0;
        end else begin
            ALERT_O <= 1'b0;
            ALERT_OE_O <= |(status_next & ~mask_reg);
        end
    end

    // ****************************************
    // Switch and power-good outputs
    // ****************************************
    // switches under PWM only while running
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            PWM_EN_O <= 1'b0;
        end else begin
            PWM_EN_O <= (state_next == ST_SOFT) || (state_next == ST_RUN);
        end
    end

    // any fault not set to ignore pulls the pin low
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            POWER_GOOD_OUT_O <= 1'b0;
            POWER_GOOD_OUT_OE_O <= 1'b1;
        end else begin
            POWER_GOOD_OUT_O <= 1'b0;
            POWER_GOOD_OUT_OE_O <= !pg_ok;
        end
    end
endmodule : pgfr_top
`default_nettype wire

// ==== pgfr_checker.sv ====
// Assertion checker for the power-good fault-response top
`timescale 1ns/1ps
`default_nettype none
module pgfr_checker #(
    parameter int SOFT_START_CYC = 20
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic REMOTE_ON_CONTROL_I,
    input wire logic HS_OC_EVT_I,
    input wire logic LS_OC_EVT_I,
    input wire logic BG_OT_I,
    input wire logic PWM_TICK_I,
    input wire logic [15:0] FEEDBACK_SENSE_I,
    input wire logic [15:0] VREF_CODE_I,
    input wire logic CMD_WR_I,
    input wire logic [7:0] CMD_CODE_I,
    input wire logic [15:0] CMD_WDATA_I,
    input wire logic [15:0] CMD_RDATA_O,
    input wire logic PWM_EN_O,
    input wire logic POWER_GOOD_OUT_O,
    input wire logic POWER_GOOD_OUT_OE_O,
    input wire logic ALERT_O
);
    logic [1:0] oc_resp_reg;
    logic [1:0] oc_cnt_reg;
    logic [2:0] evt_reg;
    logic [16:0] ov_lim;
    logic fb_hi;
    // Prebias limit stays at 5 % whatever window is chosen
    assign ov_lim = 17'(VREF_CODE_I) + 17'((24'(VREF_CODE_I) * 24'h000005) / 24'h000064);
    assign fb_hi = 17'(FEEDBACK_SENSE_I) > ov_lim;
    // Only events held three clocks count, so the pin synchronizer has seen them
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            oc_resp_reg <= 2'h1;
            oc_cnt_reg <= 2'h0;
            evt_reg <= 3'h0;
        end else begin
            evt_reg <= {evt_reg[1:0], HS_OC_EVT_I | LS_OC_EVT_I};
            if (CMD_WR_I && CMD_CODE_I == 8'h47) oc_resp_reg <= CMD_WDATA_I[1:0];
            if (PWM_TICK_I) oc_cnt_reg <= (&evt_reg) ? oc_cnt_reg + {1'b0, ~&oc_cnt_reg} : 2'h0;
        end
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_od_data;
        !POWER_GOOD_OUT_O && !ALERT_O;
    endproperty
    a_od_data: assert property (p_od_data) else $error("open-drain data high");
    property p_soft_hold;
        $rose(PWM_EN_O) |-> POWER_GOOD_OUT_OE_O [*8];
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("early release");
    property p_pwm_for_pg;
        !POWER_GOOD_OUT_OE_O |-> PWM_EN_O;
    endproperty
    a_pwm_for_pg: assert property (p_pwm_for_pg) else $error("released while off");
    property p_off_pg;
        $fell(PWM_EN_O) |-> POWER_GOOD_OUT_OE_O;
    endproperty
    a_off_pg: assert property (p_off_pg) else $error("off with output high");
    property p_bg;
        BG_OT_I [*7] |-> !PWM_EN_O && POWER_GOOD_OUT_OE_O;
    endproperty
    a_bg: assert property (p_bg) else $error("bandgap trip ignored");
    property p_prebias;
        fb_hi [*6] |-> POWER_GOOD_OUT_OE_O;
    endproperty
    a_prebias: assert property (p_prebias) else $error("prebias not flagged");
    property p_on_low;
        !REMOTE_ON_CONTROL_I [*6] |-> !PWM_EN_O && POWER_GOOD_OUT_OE_O;
    endproperty
    a_on_low: assert property (p_on_low) else $error("running while disabled");
    property p_thresh_rd;
        (CMD_WR_I && CMD_CODE_I == 8'h4f) ##1 (CMD_CODE_I == 8'h4f && !CMD_WR_I)
            |=> CMD_RDATA_O == $past(CMD_WDATA_I, 2);
    endproperty
    a_thresh_rd: assert property (p_thresh_rd) else $error("threshold lost");
    property p_oc_cut;
        PWM_TICK_I && (&evt_reg) && oc_cnt_reg == 2'h2 && PWM_EN_O
            && (oc_resp_reg == 2'h1 || oc_resp_reg == 2'h2) |-> ##[2:4] !PWM_EN_O;
    endproperty
    a_oc_cut: assert property (p_oc_cut) else $error("no overcurrent cut");
    c_start: cover property ($rose(PWM_EN_O));
    c_release: cover property ($fell(POWER_GOOD_OUT_OE_O));
    c_cut: cover property ($fell(PWM_EN_O));
endmodule : pgfr_checker
bind pgfr_top pgfr_checker #(.SOFT_START_CYC(SOFT_START_CYC)) i_pgfr_checker (
    .CORE_CLK_I, .RST_N_I, .REMOTE_ON_CONTROL_I, .HS_OC_EVT_I, .LS_OC_EVT_I, .BG_OT_I,
    .PWM_TICK_I, .FEEDBACK_SENSE_I, .VREF_CODE_I, .CMD_WR_I, .CMD_CODE_I, .CMD_WDATA_I,
    .CMD_RDATA_O, .PWM_EN_O, .POWER_GOOD_OUT_O, .POWER_GOOD_OUT_OE_O, .ALERT_O
);
`default_nettype wire

// ==== pgfr_far_end.sv ====
// Far side: pulled-up open-drain lines and a sequenced downstream converter
`timescale 1ns/1ps
`default_nettype none
module pgfr_far_end (
    input wire logic pg_oe_i,
    input wire logic alert_oe_i,
    output logic pg_line_o,
    output logic alert_n_line_o,
    output logic next_on_o
);
    // Pull-ups hold both lines high unless the device sinks them
    assign pg_line_o = !pg_oe_i;
    assign alert_n_line_o = !alert_oe_i;
    // Downstream converter is enabled only by a released power-good line
    assign next_on_o = pg_line_o;
endmodule : pgfr_far_end
`default_nettype wire

// ==== pgfr_top_bench.sv ====
// Self-checking bench for the power-good fault-response top
`timescale 1ns/1ps
`default_nettype none
module pgfr_top_bench;
    logic clk, rst_n, on, hs, ls, lsw, bg, tick, wr;
    logic [15:0] temp, fb, vref, wdata, rdata, oclim;
    logic [7:0] code;
    logic pwm, pgo, pgoe, alo, aloe, pgl, aln, nxt;
    int mismatches;
    int check_count;
    logic [7:0] rc [7] = '{8'h46, 8'h4f, 8'h51, 8'hd7, 8'h47, 8'h50, 8'h33};
    logic [15:0] rv [7] = '{16'h0023, 16'h007d, 16'h0069, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
    pgfr_top #(.SOFT_START_CYC(20)) i_pgfr_top (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .REMOTE_ON_CONTROL_I(on), .HS_OC_EVT_I(hs),
        .LS_OC_EVT_I(ls), .LS_OC_WARN_I(lsw), .BG_OT_I(bg), .PWM_TICK_I(tick),
        .TEMP_CODE_I(temp), .FEEDBACK_SENSE_I(fb), .VREF_CODE_I(vref), .CMD_WR_I(wr),
        .CMD_CODE_I(code), .CMD_WDATA_I(wdata), .CMD_RDATA_O(rdata), .OC_LIMIT_O(oclim),
        .PWM_EN_O(pwm), .POWER_GOOD_OUT_O(pgo), .POWER_GOOD_OUT_OE_O(pgoe), .ALERT_O(alo),
        .ALERT_OE_O(aloe)
    );
    pgfr_far_end i_pgfr_far_end (
        .pg_oe_i(pgoe), .alert_oe_i(aloe), .pg_line_o(pgl), .alert_n_line_o(aln), .next_on_o(nxt)
    );
    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic cy(input int n);
        repeat (n) @(negedge clk);
    endtask : cy
    task automatic ck(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : ck
    task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
        code = c;
        wdata = d;
        wr = 1'b1;
        cy(1);
        wr = 1'b0;
        cy(1);
    endtask : wr_reg
    task automatic rd_ck(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
        code = c;
        cy(1);
        ck(rdata & m, e);
    endtask : rd_ck
    task automatic pins(input logic p, input logic g);
        ck({14'h0, pwm, pgl}, {14'h0, p, g});
    endtask : pins
    // Status is sticky, so every recovery check clears it first
    task automatic clr();
        wr_reg(8'he0, 16'h00ff);
        cy(6);
    endtask : clr
    task automatic tk();
        tick = 1'b1;
        cy(1);
        tick = 1'b0;
        cy(4);
    endtask : tk
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run takes about 810 cycles
    initial begin
        #50000;
        mismatches++;
        close_out();
    end
    initial begin
        rst_n = 1'b0;
        {on, hs, ls, lsw, bg, tick, wr} = 7'h00;
        temp = 16'h0019;
        fb = 16'h03e8;
        vref = 16'h03e8;
        code = 8'h00;
        wdata = 16'h0000;
        mismatches = 0;
        check_count = 0;
        cy(3);
        rst_n = 1'b1;
        pins(1'b0, 1'b0);
        ck(oclim, 16'h0023);
        for (int i = 0; i < 7; i++) rd_ck(rc[i], 16'hffff, rv[i]);
        wr_reg(8'h4f, 16'h00a5);
        rd_ck(8'h4f, 16'hffff, 16'h00a5);
        wr_reg(8'h4f, 16'h007d);
        rd_ck(8'h4f, 16'hffff, 16'h007d);
        wr_reg(8'h46, 16'h0030);
        cy(2);
        ck(oclim, 16'h0030);
        $display("test registers done");
        on = 1'b1;
        cy(12);
        pins(1'b1, 1'b0);
        cy(30);
        pins(1'b1, 1'b1);
        ck({15'h0, nxt}, 16'h0001);
        $display("test startup done");
        wr_reg(8'hd7, 16'h000d);
        fb = 16'h0406;
        cy(6);
        pins(1'b1, 1'b1);
        fb = 16'h0407;
        cy(6);
        pins(1'b1, 1'b0);
        fb = 16'h0384;
        clr();
        pins(1'b1, 1'b1);
        fb = 16'h0383;
        cy(6);
        pins(1'b1, 1'b0);
        rd_ck(8'he0, 16'h0060, 16'h0040);
        fb = 16'h03e8;
        clr();
        pins(1'b1, 1'b1);
        $display("test window done");
        on = 1'b0;
        cy(8);
        pins(1'b0, 1'b0);
        wr_reg(8'hd7, 16'h000b);
        fb = 16'h041b;
        on = 1'b1;
        cy(40);
        pins(1'b1, 1'b0);
        rd_ck(8'he0, 16'h0020, 16'h0020);
        fb = 16'h041a;
        clr();
        pins(1'b1, 1'b1);
        fb = 16'h03a2;
        cy(6);
        pins(1'b1, 1'b1);
        fb = 16'h03a1;
        cy(6);
        pins(1'b1, 1'b0);
        fb = 16'h03e8;
        $display("test prebias done");
        temp = 16'h006e;
        cy(6);
        pins(1'b1, 1'b1);
        rd_ck(8'he0, 16'h0002, 16'h0002);
        wr_reg(8'h50, 16'h0002);
        cy(6);
        pins(1'b1, 1'b0);
        temp = 16'h0082;
        cy(6);
        pins(1'b0, 1'b0);
        temp = 16'h006a;
        cy(10);
        pins(1'b0, 1'b0);
        temp = 16'h0069;
        cy(40);
        temp = 16'h0019;
        clr();
        pins(1'b1, 1'b1);
        wr_reg(8'h50, 16'h0001);
        temp = 16'h0082;
        cy(6);
        pins(1'b0, 1'b0);
        temp = 16'h0019;
        cy(30);
        pins(1'b0, 1'b0);
        on = 1'b0;
        cy(4);
        on = 1'b1;
        wr_reg(8'h50, 16'h0000);
        cy(40);
        temp = 16'h0082;
        clr();
        pins(1'b1, 1'b1);
        rd_ck(8'he0, 16'h0001, 16'h0001);
        temp = 16'h0019;
        $display("test temperature done");
        bg = 1'b1;
        cy(8);
        pins(1'b0, 1'b0);
        rd_ck(8'he0, 16'h0004, 16'h0004);
        bg = 1'b0;
        cy(40);
        clr();
        pins(1'b1, 1'b1);
        $display("test bandgap done");
        hs = 1'b1;
        cy(4);
        tk();
        hs = 1'b0;
        cy(4);
        tk();
        tk();
        hs = 1'b1;
        cy(4);
        tk();
        tk();
        pins(1'b1, 1'b1);
        tk();
        pins(1'b0, 1'b0);
        ck({15'h0, aln}, 16'h0000);
        hs = 1'b0;
        cy(20);
        pins(1'b0, 1'b0);
        rd_ck(8'he0, 16'h0008, 16'h0008);
        wr_reg(8'he1, 16'h00ff);
        ck({15'h0, aln}, 16'h0001);
        clr();
        wr_reg(8'he1, 16'h0000);
        on = 1'b0;
        cy(4);
        on = 1'b1;
        wr_reg(8'h47, 16'h0002);
        cy(40);
        ls = 1'b1;
        cy(4);
        tk();
        tk();
        tk();
        ls = 1'b0;
        cy(125);
        pins(1'b0, 1'b0);
        cy(45);
        clr();
        pins(1'b1, 1'b1);
        wr_reg(8'h47, 16'h0000);
        hs = 1'b1;
        cy(4);
        tk();
        tk();
        tk();
        pins(1'b1, 1'b1);
        rd_ck(8'he0, 16'h0008, 16'h0008);
        hs = 1'b0;
        // Cycle off to drop the ignored fault
        on = 1'b0;
        cy(4);
        on = 1'b1;
        cy(40);
        $display("test overcurrent done");
        lsw = 1'b1;
        clr();
        pins(1'b1, 1'b1);
        wr_reg(8'h47, 16'h0001);
        cy(6);
        pins(1'b1, 1'b0);
        rd_ck(8'he0, 16'h0010, 16'h0010);
        lsw = 1'b0;
        clr();
        pins(1'b1, 1'b1);
        $display("test warning done");
        close_out();
    end
endmodule : pgfr_top_bench
`default_nettype wire
